// ---- lmie_pkg.sv ----
// Purpose: Shared constants for the literal, move and indirect-store executor
// Assumes: 14-bit instruction words, 32-bit APB data
// Notes:   Offsets are byte addresses of aligned words
package lmie_pkg;
	// ----------------------------------------
	// Widths and clock
	// ----------------------------------------
	localparam int          OP_W      = 14;
	localparam int          PTR_W     = 16;
	localparam int          CLK_HZ    = 25000000;

	// ----------------------------------------
	// Register offsets
	// ----------------------------------------
	localparam logic [7:0]  A_INSTR   = 8'h00;
	localparam logic [7:0]  A_ACC     = 8'h04;
	localparam logic [7:0]  A_BANK    = 8'h08;
	localparam logic [7:0]  A_PCH     = 8'h0C;
	localparam logic [7:0]  A_PTR0    = 8'h10;
	localparam logic [7:0]  A_PTR1    = 8'h14;
	localparam logic [7:0]  A_OPT     = 8'h18;
	localparam logic [7:0]  A_PWR     = 8'h1C;
	localparam logic [7:0]  A_STAT    = 8'h20;
	localparam logic [7:0]  A_DADDR   = 8'h24;
	localparam logic [7:0]  A_DDATA   = 8'h28;
	localparam logic [7:0]  A_EXST    = 8'h2C;

	// ----------------------------------------
	// Field positions and reset values
	// ----------------------------------------
	localparam int          PWR_SRF   = 0;
	localparam int          EXST_ILL  = 0;
	localparam int          EXST_CNT  = 8;
	localparam logic [4:0]  RST_BANK  = 5'h00;
	localparam logic [6:0]  RST_PCH   = 7'h00;
	localparam logic [7:0]  RST_ACC   = 8'h00;
	localparam logic [7:0]  RST_OPT   = 8'hFF;
	localparam logic        RST_SRF   = 1'b1;
	localparam logic [2:0]  RST_STAT  = 3'h0;
	localparam logic [15:0] RST_PTR   = 16'h0000;
	localparam logic [6:0]  IND0_F    = 7'h00;
	localparam logic [6:0]  IND1_F    = 7'h01;

	// ----------------------------------------
	// Opcode patterns and masks
	// ----------------------------------------
	localparam logic [13:0] OP_IDLE   = 14'h0000;
	localparam logic [13:0] OP_SRST   = 14'h0001;
	localparam logic [13:0] OP_OPT    = 14'h0062;
	localparam logic [13:0] OP_BANK   = 14'h0020;
	localparam logic [13:0] MSK_BANK  = 14'h3FE0;
	localparam logic [13:0] OP_PCH    = 14'h3180;
	localparam logic [13:0] MSK_PCH   = 14'h3F80;
	localparam logic [13:0] OP_ACC    = 14'h3000;
	localparam logic [13:0] MSK_ACC   = 14'h3F00;
	localparam logic [13:0] OP_STF    = 14'h0080;
	localparam logic [13:0] MSK_STF   = 14'h3F80;
	localparam logic [13:0] OP_IND    = 14'h0018;
	localparam logic [13:0] MSK_IND   = 14'h3FF8;
	localparam logic [13:0] OP_OFS    = 14'h3F80;
	localparam logic [13:0] MSK_OFS   = 14'h3F80;

	typedef enum logic [1:0] {
		LMIE_PRE_INC,
		LMIE_PRE_DEC,
		LMIE_POST_INC,
		LMIE_POST_DEC
	} lmie_upd_t;
endpackage

// ---- lmie_ptr_if.sv ----
// Purpose: Carrier between the executor and one pointer unit
// Assumes: One instance per pointer register
// Notes:   Effective address is combinational
`timescale 1ns/1ps
interface lmie_ptr_if;
	logic        clr;
	logic        ld;
	logic        upd;
	logic        ofs_mode;
	logic [1:0]  code;
	logic [5:0]  ofs;
	logic [15:0] ld_val;
	logic [15:0] ptr;
	logic [15:0] eaddr;
	modport core (output clr, ld, upd, ofs_mode, code, ofs, ld_val, input ptr, eaddr);
	modport unit (input clr, ld, upd, ofs_mode, code, ofs, ld_val, output ptr, eaddr);
endinterface

// ---- lmie_ptr_unit.sv ----
// Purpose: One 16-bit pointer register with step and offset addressing
// Assumes: Clear beats load, load beats update
// Notes:   Arithmetic wraps at the ends of the range
`timescale 1ns/1ps
module lmie_ptr_unit (
	input  wire logic   pclk,
	input  wire logic   presetn,
	input  wire logic   pce,
	lmie_ptr_if.unit    pif
);
	logic [15:0]          ptr_r;
	logic [15:0]          ptr_nxt;
	logic [15:0]          step;
	logic                 pre;
	lmie_pkg::lmie_upd_t  mode;

	assign mode = lmie_pkg::lmie_upd_t'(pif.code);
	assign pre  = (mode == lmie_pkg::LMIE_PRE_INC) || (mode == lmie_pkg::LMIE_PRE_DEC);

	always_comb begin
		step = ((mode == lmie_pkg::LMIE_PRE_INC) || (mode == lmie_pkg::LMIE_POST_INC)) ?
			ptr_r + 16'h0001 : ptr_r - 16'h0001;
		ptr_nxt = ptr_r;
		if (pif.clr) begin
			ptr_nxt = lmie_pkg::RST_PTR;
		end else if (pif.ld) begin
			ptr_nxt = pif.ld_val;
		end else if (pif.upd && !pif.ofs_mode) begin
			ptr_nxt = step;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ptr_r <= lmie_pkg::RST_PTR;
		end else if (pce) begin
			ptr_r <= ptr_nxt;
		end
	end

	assign pif.eaddr = pif.ofs_mode ? ptr_r + {{10{pif.ofs[5]}}, pif.ofs} : (pre ? step : ptr_r);
	assign pif.ptr   = ptr_r;
endmodule

// ---- lmie_core.sv ----
// Purpose: Executes literal, move, indirect-store, idle and reset instructions
// Assumes: APB master, instructions written one at a time into the instruction word
// Notes:   Each write to the instruction word is one instruction cycle
//
// Operation
// - The bank literal load puts the literal into the 5-bit bank select register and keeps all flags.
// - The high latch literal load puts a 7-bit literal into the program counter high latch, flags kept.
// - The accumulator literal load puts an 8-bit literal into the accumulator in one word, flags kept.
// - Unused opcode bits of the accumulator literal load are zero and the decoder relies on it.
// - The store to file copies the accumulator into the addressed file register, flags kept.
// - The indirect store picks one of two pointers and a 2-bit update code, pre modes using the new value.
// - The offset form stores at pointer plus a signed offset of -32 to 31 and keeps the pointer.
// - After an indirect store the pointer is one up, one down, or unchanged for the offset form.
// - Each pointer is 16 bits and wraps around at both ends.
// - Pointer updates and indirect stores change no status flag.
// - A store to an indirect access port lands at the location its pointer addresses.
// - The timer configuration load copies the accumulator into the timer configuration register.
// - The software reset resets the device, clears the soft reset flag and clears the status flags.
`timescale 1ns/1ps
module lmie_core #(
	parameter int DMEM_AW = 7
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        pce,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	output logic             soft_reset
);
	localparam int DEPTH = 1 << DMEM_AW;

	// ----------------------------------------
	// Elaboration check
	// ----------------------------------------
	if (DMEM_AW < 1 || DMEM_AW > 12) begin : g_bad_aw
		$error("DMEM_AW must lie in 1..12");
	end

	// ----------------------------------------
	// State
	// ----------------------------------------
	logic [31:0] prdata_r;
	logic        pready_r;
	logic        pslverr_r;
	logic        srst_r;
	logic [7:0]  acc_r;
	logic [4:0]  bank_r;
	logic [6:0]  pch_r;
	logic [7:0]  opt_r;
	logic        srf_r;
	logic [2:0]  stat_r;
	logic [15:0] daddr_r;
	logic [13:0] last_op_r;
	logic        ill_r;
	logic [15:0] cnt_r;
	logic [7:0]  mem_r [DEPTH];

	// ----------------------------------------
	// APB decode
	// ----------------------------------------
	logic        access;
	logic        mapped;
	logic        wr_go;
	logic [13:0] op;

	assign access = psel && penable;
	assign mapped = (paddr[1:0] == 2'b00) && (paddr <= lmie_pkg::A_EXST);
	assign wr_go  = pce && access && pready_r && pwrite && mapped;
	assign op     = pwdata[13:0];

	function automatic logic wr_at(input logic [7:0] a);
		return wr_go && (paddr == a);
	endfunction

	// One wait state so that read data leaves a flip-flop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
		end else if (pce) begin
			pready_r  <= access && !pready_r;
			pslverr_r <= access && !pready_r && !mapped;
		end
	end

	// ----------------------------------------
	// Instruction decode
	// ----------------------------------------
	logic exec;
	logic is_idle;
	logic is_srst;
	logic is_opt;
	logic is_bank;
	logic is_pch;
	logic is_acc;
	logic is_stf;
	logic is_ind;
	logic is_ofs;
	logic known;

	assign exec    = wr_at(lmie_pkg::A_INSTR);
	assign is_idle = op == lmie_pkg::OP_IDLE;
	assign is_srst = op == lmie_pkg::OP_SRST;
	assign is_opt  = op == lmie_pkg::OP_OPT;
	assign is_bank = (op & lmie_pkg::MSK_BANK) == lmie_pkg::OP_BANK;
	assign is_pch  = (op & lmie_pkg::MSK_PCH) == lmie_pkg::OP_PCH;
	assign is_acc  = (op & lmie_pkg::MSK_ACC) == lmie_pkg::OP_ACC;
	assign is_stf  = (op & lmie_pkg::MSK_STF) == lmie_pkg::OP_STF;
	assign is_ind  = (op & lmie_pkg::MSK_IND) == lmie_pkg::OP_IND;
	assign is_ofs  = (op & lmie_pkg::MSK_OFS) == lmie_pkg::OP_OFS;
	assign known   = is_idle || is_srst || is_opt || is_bank || is_pch || is_acc
		|| is_stf || is_ind || is_ofs;

	// ----------------------------------------
	// Pointer units
	// ----------------------------------------
	lmie_ptr_if pif [2] ();
	logic [15:0] ptr_v [2];
	logic [15:0] ea_v [2];

	for (genvar i = 0; i < 2; i++) begin : g_ptr
		assign pif[i].clr      = exec && is_srst;
		assign pif[i].ld       = wr_at(i == 0 ? lmie_pkg::A_PTR0 : lmie_pkg::A_PTR1);
		assign pif[i].upd      = exec && ((is_ind && op[2] == 1'(i)) || (is_ofs && op[6] == 1'(i)));
		assign pif[i].ofs_mode = is_ofs;
		assign pif[i].code     = op[1:0];
		assign pif[i].ofs      = op[5:0];
		assign pif[i].ld_val   = pwdata[15:0];
		assign ptr_v[i]        = pif[i].ptr;
		assign ea_v[i]         = pif[i].eaddr;
		lmie_ptr_unit u_ptr (
			.pclk    (pclk),
			.presetn (presetn),
			.pce     (pce),
			.pif     (pif[i])
		);
	end

	// ----------------------------------------
	// Data store target
	// ----------------------------------------
	logic [15:0] st_addr;
	logic        st_en;

	always_comb begin
		st_addr = {4'h0, bank_r, op[6:0]};
		st_en   = 1'b0;
		if (exec && is_stf) begin
			st_en = 1'b1;
			if (op[6:0] == lmie_pkg::IND0_F) begin
				st_addr = ptr_v[0];
			end else if (op[6:0] == lmie_pkg::IND1_F) begin
				st_addr = ptr_v[1];
			end
		end else if (exec && is_ind) begin
			st_en   = 1'b1;
			st_addr = ea_v[op[2]];
		end else if (exec && is_ofs) begin
			st_en   = 1'b1;
			st_addr = ea_v[op[6]];
		end
	end

	always_ff @(posedge pclk) begin
		if (pce && st_en) begin
			mem_r[st_addr[DMEM_AW-1:0]] <= acc_r;
		end else if (pce && wr_at(lmie_pkg::A_DDATA)) begin
			mem_r[daddr_r[DMEM_AW-1:0]] <= pwdata[7:0];
		end
	end

	// ----------------------------------------
	// Architectural registers
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			acc_r <= lmie_pkg::RST_ACC;
		end else if (pce) begin
			if (exec && is_srst) begin
				acc_r <= lmie_pkg::RST_ACC;
			end else if (exec && is_acc) begin
				acc_r <= op[7:0];
			end else if (wr_at(lmie_pkg::A_ACC)) begin
				acc_r <= pwdata[7:0];
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bank_r <= lmie_pkg::RST_BANK;
		end else if (pce) begin
			if (exec && is_srst) begin
				bank_r <= lmie_pkg::RST_BANK;
			end else if (exec && is_bank) begin
				bank_r <= op[4:0];
			end else if (wr_at(lmie_pkg::A_BANK)) begin
				bank_r <= pwdata[4:0];
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pch_r <= lmie_pkg::RST_PCH;
		end else if (pce) begin
			if (exec && is_srst) begin
				pch_r <= lmie_pkg::RST_PCH;
			end else if (exec && is_pch) begin
				pch_r <= op[6:0];
			end else if (wr_at(lmie_pkg::A_PCH)) begin
				pch_r <= pwdata[6:0];
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			opt_r <= lmie_pkg::RST_OPT;
		end else if (pce) begin
			if (exec && is_srst) begin
				opt_r <= lmie_pkg::RST_OPT;
			end else if (exec && is_opt) begin
				opt_r <= acc_r;
			end else if (wr_at(lmie_pkg::A_OPT)) begin
				opt_r <= pwdata[7:0];
			end
		end
	end

	// flags only move by software write or software reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stat_r <= lmie_pkg::RST_STAT;
		end else if (pce) begin
			if (exec && is_srst) begin
				stat_r <= lmie_pkg::RST_STAT;
			end else if (wr_at(lmie_pkg::A_STAT)) begin
				stat_r <= pwdata[2:0];
			end
		end
	end

	// ----------------------------------------
	// Software reset
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			srf_r  <= lmie_pkg::RST_SRF;
			srst_r <= 1'b0;
		end else if (pce) begin
			srst_r <= exec && is_srst;
			if (exec && is_srst) begin
				srf_r <= 1'b0;
			end else if (wr_at(lmie_pkg::A_PWR)) begin
				srf_r <= pwdata[lmie_pkg::PWR_SRF];
			end
		end
	end

	// ----------------------------------------
	// Execution status
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			last_op_r <= lmie_pkg::OP_IDLE;
			ill_r     <= 1'b0;
			cnt_r     <= 16'h0000;
			daddr_r   <= 16'h0000;
		end else if (pce) begin
			if (exec) begin
				last_op_r <= op;
				cnt_r     <= cnt_r + 16'h0001;
			end
			// Unknown opcode wins over a same-cycle clear
			if (exec && !known) begin
				ill_r <= 1'b1;
			end else if (wr_at(lmie_pkg::A_EXST) && pwdata[lmie_pkg::EXST_ILL]) begin
				ill_r <= 1'b0;
			end
			if (wr_at(lmie_pkg::A_DADDR)) begin
				daddr_r <= pwdata[15:0];
			end
		end
	end

	// ----------------------------------------
	// Read data
	// ----------------------------------------
	logic [31:0] rd_nxt;

	always_comb begin
		rd_nxt = 32'h0000_0000;
		unique case (paddr)
			lmie_pkg::A_INSTR: rd_nxt[13:0] = last_op_r;
			lmie_pkg::A_ACC:   rd_nxt[7:0]  = acc_r;
			lmie_pkg::A_BANK:  rd_nxt[4:0]  = bank_r;
			lmie_pkg::A_PCH:   rd_nxt[6:0]  = pch_r;
			lmie_pkg::A_PTR0:  rd_nxt[15:0] = ptr_v[0];
			lmie_pkg::A_PTR1:  rd_nxt[15:0] = ptr_v[1];
			lmie_pkg::A_OPT:   rd_nxt[7:0]  = opt_r;
			lmie_pkg::A_PWR:   rd_nxt[lmie_pkg::PWR_SRF] = srf_r;
			lmie_pkg::A_STAT:  rd_nxt[2:0]  = stat_r;
			lmie_pkg::A_DADDR: rd_nxt[15:0] = daddr_r;
			lmie_pkg::A_DDATA: rd_nxt[7:0]  = mem_r[daddr_r[DMEM_AW-1:0]];
			lmie_pkg::A_EXST: begin
				rd_nxt[lmie_pkg::EXST_ILL]           = ill_r;
				rd_nxt[lmie_pkg::EXST_CNT +: 16]     = cnt_r;
			end
			default:           rd_nxt = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_r <= 32'h0000_0000;
		end else if (pce && access && !pready_r) begin
			prdata_r <= rd_nxt;
		end
	end

	assign prdata     = prdata_r;
	assign pready     = pready_r;
	assign pslverr    = pslverr_r;
	assign soft_reset = srst_r;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	chk_bank_load: assert property (exec && is_bank |=> bank_r == $past(op[4:0]))
		else $error("bank literal not loaded");
	chk_pch_load: assert property (exec && is_pch |=> pch_r == $past(op[6:0]))
		else $error("high latch literal not loaded");
	chk_acc_load: assert property (exec && is_acc && !is_pch |=> acc_r == $past(op[7:0]))
		else $error("accumulator literal not loaded");
	chk_file_store: assert property (exec && is_stf && op[6:1] != 6'h00 |=>
		mem_r[$past(st_addr[DMEM_AW-1:0])] == $past(acc_r))
		else $error("file store lost");
	chk_ptr_step: assert property (exec && is_ind && !op[2] |=>
		ptr_v[0] == ($past(op[0]) ? $past(ptr_v[0]) - 16'h0001 : $past(ptr_v[0]) + 16'h0001))
		else $error("pointer step wrong");
	chk_ofs_hold: assert property (exec && is_ofs |=> $stable(ptr_v[0]) && $stable(ptr_v[1]))
		else $error("offset form moved pointer");
	chk_flags_kept: assert property (exec && !is_srst |=> $stable(stat_r))
		else $error("status flags changed");
	chk_opt_load: assert property (exec && is_opt |=> opt_r == $past(acc_r))
		else $error("timer configuration not loaded");
	chk_soft_reset: assert property (exec && is_srst |=> soft_reset && !srf_r ##1 !soft_reset)
		else $error("software reset pulse wrong");
	chk_idle_quiet: assert property (exec && is_idle |=> $stable(acc_r) && $stable(bank_r)
		&& $stable(pch_r) && $stable(opt_r))
		else $error("idle changed state");
	chk_bus_answer: assert property (access && !pready_r && pce |=> pready)
		else $error("no answer after one wait");

	cov_indirect: cover property (exec && is_ind ##[2:20] exec && is_ind);
	cov_port_store: cover property (exec && is_stf && op[6:0] == lmie_pkg::IND1_F);
	cov_soft_reset: cover property (exec && is_srst);
endmodule

// ---- lmie_tb_top.sv ----
// Purpose: Self-checking bench for the literal, move and indirect-store executor
// Assumes: APB access only, pce held high, data store of 2**AW bytes
// Notes:   Flags are preset to a nonzero pattern so that any change shows
`timescale 1ns/1ps
module lmie_tb_top;
	localparam int AW = 7;

	logic        pclk;
	logic        presetn;
	logic        pce;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        soft_reset;
	int          n_errors = 0;
	int          n_tests = 0;
	int          n_pulses = 0;
	int          p0;
	logic [31:0] rdat;
	logic        rerr;
	logic [15:0] cnt;
	logic [15:0] base;
	logic [15:0] step;
	logic [15:0] ea;
	logic [7:0]  val;

	lmie_core #(.DMEM_AW(AW)) DUT (
		.pclk       (pclk),
		.presetn    (presetn),
		.pce        (pce),
		.psel       (psel),
		.penable    (penable),
		.pwrite     (pwrite),
		.paddr      (paddr),
		.pwdata     (pwdata),
		.prdata     (prdata),
		.pready     (pready),
		.pslverr    (pslverr),
		.soft_reset (soft_reset)
	);

	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end

	always @(posedge pclk) begin
		if (soft_reset === 1'b1) begin
			n_pulses++;
		end
	end

	// ----------------------------------------
	// Checking and bus tasks
	// ----------------------------------------
	task automatic finish_test();
		$display("Checks made: %0d, mismatches: %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// Request held until pready is seen at a rising edge
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		i = 0;
		do begin
			@(posedge pclk);
			i++;
		end while (pready !== 1'b1 && i < 16);
		if (pready !== 1'b1) begin
			n_errors++;
			$display("ERROR pready expected 1 seen %b", pready);
			finish_test();
		end
		rdat = prdata;
		rerr = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask

	task automatic rd(input string what, input logic [7:0] a, input logic [31:0] exp);
		xfer(1'b0, a, 32'h00000000);
		check(what, rdat, exp);
	endtask

	task automatic exec(input logic [13:0] op);
		wr(lmie_pkg::A_INSTR, {18'h00000, op});
	endtask

	task automatic setacc(input logic [7:0] v);
		exec(lmie_pkg::OP_ACC | {6'h00, v});
	endtask

	task automatic mem(input string what, input logic [15:0] a, input logic [7:0] exp);
		wr(lmie_pkg::A_DADDR, {16'h0000, a});
		rd(what, lmie_pkg::A_DDATA, {24'h000000, exp});
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		presetn = 1'b0;
		pce     = 1'b1;
		psel    = 1'b0;
		penable = 1'b0;
		pwrite  = 1'b0;
		paddr   = 8'h00;
		pwdata  = 32'h00000000;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		rd("opt rst", lmie_pkg::A_OPT, 32'h000000FF);
		rd("pwr rst", lmie_pkg::A_PWR, 32'h00000001);
		wr(lmie_pkg::A_STAT, 32'h00000005);
		// Literals at the top of their ranges, except the bank literal at 0F
		exec(lmie_pkg::OP_BANK | 14'h000F);
		rd("bank", lmie_pkg::A_BANK, 32'h0000000F);
		exec(lmie_pkg::OP_PCH | 14'h007F);
		rd("pch", lmie_pkg::A_PCH, 32'h0000007F);
		setacc(8'hFF);
		rd("acc", lmie_pkg::A_ACC, 32'h000000FF);
		setacc(8'h4F);
		exec(lmie_pkg::OP_STF | 14'h0020);
		mem("file", 16'h0020, 8'h4F);
		xfer(1'b0, lmie_pkg::A_EXST, 32'h00000000);
		cnt = rdat[23:8];
		exec(lmie_pkg::OP_IDLE);
		rd("count", lmie_pkg::A_EXST, {8'h00, cnt + 16'h0001, 8'h00});
		rd("acc idle", lmie_pkg::A_ACC, 32'h0000004F);
		exec(lmie_pkg::OP_OPT);
		rd("opt", lmie_pkg::A_OPT, 32'h0000004F);
		// Every update code on both pointers, pointer 1 at the wrap ends
		for (int n = 0; n < 2; n++) begin
			for (int m = 0; m < 4; m++) begin
				base = (n == 0) ? 16'h0010 : (m[0] ? 16'h0000 : 16'hFFFF);
				step = m[0] ? 16'hFFFF : 16'h0001;
				ea   = m[1] ? base : base + step;
				val  = 8'hA0 + 8'(n * 4 + m);
				wr((n == 1) ? lmie_pkg::A_PTR1 : lmie_pkg::A_PTR0, {16'h0000, base});
				setacc(val);
				exec(lmie_pkg::OP_IND | 14'(n << 2) | 14'(m));
				rd("ptr", (n == 1) ? lmie_pkg::A_PTR1 : lmie_pkg::A_PTR0, {16'h0000, base + step});
				mem("ind", ea, val);
			end
		end
		// Offset form at both ends of the signed range
		for (int k = 0; k < 2; k++) begin
			ea  = 16'h0040 + ((k == 1) ? 16'h001F : 16'hFFE0);
			val = 8'hC0 + 8'(k);
			wr((k == 1) ? lmie_pkg::A_PTR1 : lmie_pkg::A_PTR0, 32'h00000040);
			setacc(val);
			exec(lmie_pkg::OP_OFS | 14'(k << 6) | ((k == 1) ? 14'h001F : 14'h0020));
			rd("ofs ptr", (k == 1) ? lmie_pkg::A_PTR1 : lmie_pkg::A_PTR0, 32'h00000040);
			mem("ofs", ea, val);
		end
		wr(lmie_pkg::A_PTR0, 32'h00000033);
		setacc(8'h77);
		exec(lmie_pkg::OP_STF);
		mem("port", 16'h0033, 8'h77);
		rd("stat", lmie_pkg::A_STAT, 32'h00000005);
		xfer(1'b0, 8'h30, 32'h00000000);
		check("unmapped err", {31'h00000000, rerr}, 32'h00000001);
		// Unknown opcode raises the sticky flag and leaves the accumulator alone
		exec(14'h2000);
		xfer(1'b0, lmie_pkg::A_EXST, 32'h00000000);
		check("ill set", {31'h00000000, rdat[lmie_pkg::EXST_ILL]}, 32'h00000001);
		rd("acc ill", lmie_pkg::A_ACC, 32'h00000077);
		wr(lmie_pkg::A_EXST, 32'h00000001);
		xfer(1'b0, lmie_pkg::A_EXST, 32'h00000000);
		check("ill clr", {31'h00000000, rdat[lmie_pkg::EXST_ILL]}, 32'h00000000);
		// Software reset pulses once, clears the soft reset flag and restores defaults
		p0 = n_pulses;
		exec(lmie_pkg::OP_SRST);
		repeat (4) @(posedge pclk);
		check("pulses", 32'(n_pulses - p0), 32'h00000001);
		rd("pwr", lmie_pkg::A_PWR, 32'h00000000);
		rd("acc srst", lmie_pkg::A_ACC, 32'h00000000);
		rd("bank srst", lmie_pkg::A_BANK, 32'h00000000);
		rd("ptr srst", lmie_pkg::A_PTR0, 32'h00000000);
		rd("opt srst", lmie_pkg::A_OPT, 32'h000000FF);
		finish_test();
	end
endmodule
